// file: rtl/clock_manager_status_config.v
// Clock manager status word, reconfiguration handshake and static settings
`timescale 1ns/100ps
`default_nettype none
`include "clock_manager_consts.vh"
module clock_manager_status_config #(
  // Feedback: 1 single-rate, 0 none
  parameter [0:0] FEEDBACK_TYPE = `FB_ONE_X,
  // Divided output factor in half steps (4 means 2.0)
  parameter [5:0] DIVIDED_OUTPUT_FACTOR = `DIV_FACTOR_DEF,
  parameter [5:0] SYNTH_DIVISOR = `SYNTH_DIV_DEF,
  parameter [5:0] SYNTH_MULTIPLIER = `SYNTH_MUL_DEF,
  parameter [0:0] INPUT_HALVING = 1'h0,
  // Period hint in tenths of a nanosecond
  parameter [15:0] INPUT_PERIOD_HINT = `PERIOD_HINT_DEF,
  parameter [2:0] PHASE_OFFSET_MODE = `PHASE_MODE_NONE
) (
  input wire clk,
  input wire reset,
  input wire managerLocked,
  input wire inputClock,
  input wire feedbackClock,
  input wire synthesizedClock,
  input wire phaseLimitHit,
  input wire delayRangeHit,
  input wire reconfigEnable,
  input wire reconfigWriteEnable,
  input wire [6:0] reconfigAddress,
  input wire [15:0] reconfigWriteBus,
  input wire [15:0] reconfigReadData,
  output reg [15:0] statusWord_q,
  output reg reconfigReady_q,
  output reg inputEnable_q,
  output reg unityEnable_q,
  output reg feedbackUsed_q,
  output reg synthRestartBlock_q,
  output reg configError_q
);
  // =====================================================================
  // States of the reconfiguration handshake (one-hot)
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_ANSWER = 2'b10;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [15:0] readHold_q;
  reg halfPhase_q;
  reg overflow_q;
  reg lockMeta_q;
  reg lockSync_q;
  reg phaseMeta_q;
  reg phaseSync_q;
  reg rangeMeta_q;
  reg rangeSync_q;
  wire inToggled;
  wire fbToggled;
  wire fxToggled;
  wire inStopped;
  wire fbStopped;
  wire fxStopped;
  wire inTick;
  wire flagsClear;
  wire factorOk;
  wire divisorOk;
  wire multiplierOk;
  wire modeOk;
  wire hintOk;
  reg [15:0] statusFlags;

  // Range check used on the factor, divisor and multiplier settings
  function inRange;
    input [5:0] value;
    input [5:0] lo;
    input [5:0] hi;
    begin
      inRange = (value >= lo) && (value <= hi);
    end
  endfunction

  // Above the half-step band only whole factors exist, so odd half steps are refused
  function factorLegal;
    input [5:0] halfSteps;
    begin
      factorLegal = inRange(halfSteps, `DIV_FACTOR_MIN, `DIV_FACTOR_MAX)
        && ((halfSteps <= `DIV_FACTOR_HALF_TOP) || !halfSteps[`DIV_FACTOR_HALF_BIT]);
    end
  endfunction

  // =====================================================================
  // Pin synchronisers for clocks under watch
  clock_activity_sync inSync (
    .clk(clk),
    .reset(reset),
    .clockPin(inputClock),
    .toggled_q(inToggled)
  );
  clock_activity_sync fbSync (
    .clk(clk),
    .reset(reset),
    .clockPin(feedbackClock),
    .toggled_q(fbToggled)
  );
  clock_activity_sync fxSync (
    .clk(clk),
    .reset(reset),
    .clockPin(synthesizedClock),
    .toggled_q(fxToggled)
  );

  always @(posedge clk) begin
    if (reset) begin
      lockMeta_q <= 1'b0;
      lockSync_q <= 1'b0;
      phaseMeta_q <= 1'b0;
      phaseSync_q <= 1'b0;
      rangeMeta_q <= 1'b0;
      rangeSync_q <= 1'b0;
    end else begin
      lockMeta_q <= managerLocked;
      lockSync_q <= lockMeta_q;
      phaseMeta_q <= phaseLimitHit;
      phaseSync_q <= phaseMeta_q;
      rangeMeta_q <= delayRangeHit;
      rangeSync_q <= rangeMeta_q;
    end
  end

  assign flagsClear = !lockSync_q;

  // Input-clock edges time the feedback and synthesized watchers; a half-period
  // is counted per toggle, so inTick fires once per input cycle.
  assign inTick = inToggled && halfPhase_q;

  always @(posedge clk) begin
    if (reset) begin
      halfPhase_q <= 1'b0;
    end else if (inToggled) begin
      halfPhase_q <= !halfPhase_q;
    end
  end

  // =====================================================================
  // Stop detectors
  // Input stop, sampled on the system clock as ticks
  stop_watch #(
    .CNT_W(`INSTOP_CNT_W),
    .LIMIT(`INSTOP_LIMIT),
    .STICKY(0)
  ) inWatch (
    .clk(clk),
    .reset(reset),
    .tick(1'b1),
    .toggled(inToggled),
    .clear(flagsClear),
    .stopped_q(inStopped)
  );
  // Feedback stop, single missing edges absorbed
  stop_watch #(
    .CNT_W(`FBSTOP_CNT_W),
    .LIMIT(`FBSTOP_LIMIT),
    .STICKY(0)
  ) fbWatch (
    .clk(clk),
    .reset(reset),
    .tick(inTick),
    .toggled(fbToggled),
    .clear(flagsClear || !feedbackUsed_q),
    .stopped_q(fbStopped)
  );
  stop_watch #(
    .CNT_W(`SYNTHSTOP_CNT_W),
    .LIMIT(`SYNTHSTOP_LIMIT),
    .STICKY(1)
  ) fxWatch (
    .clk(clk),
    .reset(reset),
    .tick(inTick),
    .toggled(fxToggled),
    .clear(flagsClear && !synthRestartBlock_q),
    .stopped_q(fxStopped)
  );

  // =====================================================================
  // Phase overflow flag
  always @(posedge clk) begin
    if (reset || flagsClear) begin
      overflow_q <= 1'b0;
    end else begin
      overflow_q <= phaseSync_q || rangeSync_q;
    end
  end

  always @* begin
    statusFlags = `STAT_ZERO;
    statusFlags[`STAT_OVERFLOW_BIT] = overflow_q;
    // Stop flags masked whenever the synchronised lock is low
    statusFlags[`STAT_INSTOP_BIT] = inStopped && !flagsClear;
    statusFlags[`STAT_SYNTHSTOP_BIT] = fxStopped && !flagsClear;
    statusFlags[`STAT_FBSTOP_BIT] = fbStopped && !flagsClear;
  end

  // =====================================================================
  // Reconfiguration handshake
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (reconfigEnable) begin
          state_d = ST_ANSWER;
        end
      end
      // Enable seen here is dropped; the partner must space its requests
      ST_ANSWER: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk) begin
    if (reset) begin
      state_q <= ST_IDLE;
      reconfigReady_q <= 1'b0;
      readHold_q <= `STAT_ZERO;
      statusWord_q <= `STAT_ZERO;
    end else begin
      state_q <= state_d;
      reconfigReady_q <= (state_q == ST_ANSWER);
      if (state_q == ST_IDLE && reconfigEnable) begin
        readHold_q <= reconfigWriteEnable ? `STAT_ZERO : reconfigReadData;
      end
      if (state_q == ST_ANSWER) begin
        statusWord_q <= readHold_q;
      end else if (!reconfigEnable) begin
        statusWord_q <= statusFlags;
      end
    end
  end

  // =====================================================================
  // Static settings
  always @(posedge clk) begin
    if (reset) begin
      inputEnable_q <= 1'b0;
      unityEnable_q <= 1'b0;
      feedbackUsed_q <= 1'b0;
      synthRestartBlock_q <= 1'b0;
      configError_q <= 1'b0;
    end else begin
      // Halving gates every other input edge
      inputEnable_q <= INPUT_HALVING ? (inToggled && halfPhase_q) : inToggled;
      // Unity clock enabled whenever no input stop is flagged
      unityEnable_q <= !inStopped;
      feedbackUsed_q <= (FEEDBACK_TYPE == `FB_ONE_X);
      // Synthesized clock held off once stopped
      synthRestartBlock_q <= synthRestartBlock_q || fxStopped;
      configError_q <= !(factorOk && divisorOk && multiplierOk && modeOk && hintOk);
    end
  end

  // =====================================================================
  // Setting range checks
  // Half steps to 7.5, whole factors to 16
  assign factorOk = factorLegal(DIVIDED_OUTPUT_FACTOR);
  assign divisorOk = inRange(SYNTH_DIVISOR, `SYNTH_DIV_MIN, `SYNTH_DIV_MAX);
  assign multiplierOk = inRange(SYNTH_MULTIPLIER, `SYNTH_MUL_MIN, `SYNTH_MUL_MAX);
  assign modeOk = (PHASE_OFFSET_MODE <= `PHASE_MODE_DIRECT);
  // All ones cannot be a real period
  assign hintOk = (INPUT_PERIOD_HINT != `PERIOD_HINT_BAD);
endmodule
`default_nettype wire

// file: rtl/clock_manager_consts.vh
// Constants for the clock manager status and configuration slice
`ifndef CLOCK_MANAGER_CONSTS_VH
`define CLOCK_MANAGER_CONSTS_VH
// =====================================================================
// Status word layout
`define STAT_WIDTH 16
`define STAT_OVERFLOW_BIT 0
`define STAT_INSTOP_BIT 1
`define STAT_SYNTHSTOP_BIT 2
`define STAT_FBSTOP_BIT 3
`define STAT_ZERO 16'h0000
// =====================================================================
// Stop detection limits: input stop in system-clock cycles, the others in input-clock cycles
`define INSTOP_LIMIT 4'h8
`define FBSTOP_LIMIT 3'h5
`define SYNTHSTOP_LIMIT 9'h101
`define INSTOP_CNT_W 4
`define FBSTOP_CNT_W 3
`define SYNTHSTOP_CNT_W 9
// =====================================================================
// Configuration encodings and defaults
`define FB_ONE_X 1'h1
`define FB_NONE 1'h0
`define DIV_FACTOR_DEF 6'h04
`define DIV_FACTOR_MIN 6'h03
`define DIV_FACTOR_MAX 6'h20
`define DIV_FACTOR_HALF_TOP 6'h0F
`define DIV_FACTOR_HALF_BIT 0
`define SYNTH_DIV_DEF 6'h01
`define SYNTH_DIV_MIN 6'h01
`define SYNTH_DIV_MAX 6'h20
`define SYNTH_MUL_DEF 6'h04
`define SYNTH_MUL_MIN 6'h02
`define SYNTH_MUL_MAX 6'h20
`define PHASE_MODE_NONE 3'h0
`define PHASE_MODE_FIXED 3'h1
`define PHASE_MODE_OFFSET_A 3'h2
`define PHASE_MODE_CENTERED 3'h3
`define PHASE_MODE_DIRECT 3'h4
`define PERIOD_HINT_DEF 16'h0000
`define PERIOD_HINT_BAD 16'hFFFF
`endif

// file: rtl/stop_watch.v
// Stop detector: counts sampling ticks since the watched clock last toggled
`timescale 1ns/100ps
`default_nettype none
module stop_watch #(
  parameter CNT_W = 4,
  parameter [CNT_W-1:0] LIMIT = 4'h8,
  parameter STICKY = 0
) (
  input wire clk,
  input wire reset,
  input wire tick,
  input wire toggled,
  input wire clear,
  output reg stopped_q
);
  reg [CNT_W-1:0] idle_q;
  // =====================================================================
  // Idle counter
  always @(posedge clk) begin
    if (reset || clear) begin
      idle_q <= {CNT_W{1'b0}};
      stopped_q <= 1'b0;
    end else begin
      if (toggled) begin
        idle_q <= {CNT_W{1'b0}};
      end else if (tick && idle_q != LIMIT) begin
        idle_q <= idle_q + {{(CNT_W-1){1'b0}}, 1'b1};
      end
      if (idle_q == LIMIT && !toggled) begin
        stopped_q <= 1'b1;
      end else if (toggled && STICKY == 0) begin
        stopped_q <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// file: rtl/clock_activity_sync.v
// Two-stage synchroniser with toggle detection for a watched clock
`timescale 1ns/100ps
`default_nettype none
module clock_activity_sync (
  input wire clk,
  input wire reset,
  input wire clockPin,
  output reg toggled_q
);
  reg meta_q;
  reg sync_q;
  reg last_q;
  // =====================================================================
  // Synchroniser and edge detector
  always @(posedge clk) begin
    if (reset) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
      toggled_q <= 1'b0;
    end else begin
      meta_q <= clockPin;
      sync_q <= meta_q;
      last_q <= sync_q;
      toggled_q <= sync_q ^ last_q;
    end
  end
endmodule
`default_nettype wire

// file: verification/clock_manager_status_config_sva.sv
// Checker for the clock manager status word and reconfiguration answer
`timescale 1ns/100ps
`default_nettype none
module clock_manager_status_config_sva #(
  parameter [0:0] FEEDBACK_TYPE = 1'h1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic managerLocked,
  input wire logic inputClock,
  input wire logic reconfigEnable,
  input wire logic [15:0] reconfigReadData,
  input wire logic [15:0] statusWord_q,
  input wire logic reconfigReady_q,
  input wire logic feedbackUsed_q,
  input wire logic synthRestartBlock_q
);
  // ====
  // Helpers
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic [7:0] inIdle_q;
  logic lastIn_q;
  // Saturates so a long stop never wraps back to a match
  always @(posedge clk) begin
    lastIn_q <= inputClock;
    if (reset || inputClock != lastIn_q) inIdle_q <= 8'h00;
    else if (inIdle_q != 8'hFF) inIdle_q <= inIdle_q + 8'h01;
  end
  sequence s_view;
    !reconfigEnable [*3];
  endsequence
  // Sixteen locked cycles cover the lock sync and the whole stop count
  sequence s_lock;
    managerLocked [*8] ##1 managerLocked [*8];
  endsequence
  // ====
  // Properties
  AST_ANSWER: assert property (reconfigEnable && !$past(reconfigEnable) &&
    !$past(reconfigEnable, 2) && !reconfigReady_q |-> ##2 reconfigReady_q)
    else $error("request not answered");
  AST_READY_ONE: assert property (reconfigReady_q |=> !reconfigReady_q)
    else $error("ready longer than one cycle");
  AST_READY_CAUSE: assert property ($rose(reconfigReady_q) |-> $past(reconfigEnable, 2))
    else $error("ready without request");
  AST_READ_DATA: assert property (reconfigReady_q |->
    statusWord_q == $past(reconfigReadData, 2))
    else $error("answer data wrong");
  AST_TOP_ZERO: assert property (s_view |-> statusWord_q[15:4] == 12'h000)
    else $error("unassigned status bits set");
  AST_NOLOCK: assert property (((!managerLocked) [*2] ##1
    ((!managerLocked) [*3] and s_view)) |-> statusWord_q[3:0] == 4'h0)
    else $error("flag high without lock");
  AST_INSTOP: assert property (s_lock ##0 s_view ##0 (inIdle_q == 8'h10) |->
    statusWord_q[1])
    else $error("input stop not flagged");
  AST_STICKY: assert property (synthRestartBlock_q |=> synthRestartBlock_q)
    else $error("restart block dropped");
  AST_FB_TYPE: assert property (!$past(reset) && !$past(reset, 2) |->
    feedbackUsed_q == FEEDBACK_TYPE)
    else $error("feedback type wrong");
endmodule
bind clock_manager_status_config clock_manager_status_config_sva #(
  .FEEDBACK_TYPE(FEEDBACK_TYPE)
) u_sva (.clk(clk), .reset(reset), .managerLocked(managerLocked),
  .inputClock(inputClock), .reconfigEnable(reconfigEnable),
  .reconfigReadData(reconfigReadData), .statusWord_q(statusWord_q),
  .reconfigReady_q(reconfigReady_q), .feedbackUsed_q(feedbackUsed_q),
  .synthRestartBlock_q(synthRestartBlock_q));
`default_nettype wire

// file: verification/fabric_partner.sv
// Fabric-side user of the reconfiguration port
`timescale 1ns/100ps
`default_nettype none
module fabric_partner (
  input wire logic clk,
  input wire logic go,
  output logic reconfigEnable,
  output logic reconfigWriteEnable,
  output logic [6:0] reconfigAddress,
  output logic [15:0] reconfigWriteBus
);
  // ====
  // Port drive
  // idle port zero
  assign reconfigWriteEnable = 1'h0;
  assign reconfigAddress = 7'h00;
  assign reconfigWriteBus = 16'h0000;
  // One-cycle request pulse; caller keeps requests well apart
  initial reconfigEnable = 1'h0;
  always @(posedge clk) reconfigEnable <= #1 go;
endmodule
`default_nettype wire

// file: verification/tb_top.sv
// Self-checking bench for the clock manager status slice
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk = 1'h0, reset = 1'h1, managerLocked = 1'h0, go = 1'h0;
  logic inputClock = 1'h0, feedbackClock = 1'h0, synthesizedClock = 1'h0;
  logic phaseLimitHit = 1'h0, delayRangeHit = 1'h0;
  logic inRun = 1'h1, fbRun = 1'h1, synRun = 1'h1;
  logic [2:0] phase = 3'h0;
  logic [15:0] readData = 16'h0000;
  logic [15:0] expQ[$];
  int errCount = 0, checkCount = 0, cycles = 0;
  logic [15:0] inEnCount = 16'h0000;
  wire en, we, rdy, inEn, unityEn, fbUsed, block, cfgErr;
  wire [6:0] addr;
  wire [15:0] wbus, status;
  // ====
  // Clocks and watched clocks
  always #12.5 clk = ~clk;
  // Watched clocks toggle every 8 cycles, fast enough for the stop timers
  always @(posedge clk) begin
    phase <= #1 phase + 3'h1;
    if (phase == 3'h7 && inRun) begin
      inputClock <= #1 ~inputClock;
      if (fbRun) feedbackClock <= #1 ~feedbackClock;
      if (synRun) synthesizedClock <= #1 ~synthesizedClock;
    end
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 8000) begin
      errCount++;
      closeOut();
    end
  end
  // ====
  // Instances
  fabric_partner u_fabric_partner (.clk(clk), .go(go), .reconfigEnable(en),
    .reconfigWriteEnable(we), .reconfigAddress(addr), .reconfigWriteBus(wbus));
  clock_manager_status_config u_clock_manager_status_config (.clk(clk),
    .reset(reset), .managerLocked(managerLocked), .inputClock(inputClock),
    .feedbackClock(feedbackClock), .synthesizedClock(synthesizedClock),
    .phaseLimitHit(phaseLimitHit), .delayRangeHit(delayRangeHit),
    .reconfigEnable(en), .reconfigWriteEnable(we), .reconfigAddress(addr),
    .reconfigWriteBus(wbus), .reconfigReadData(readData), .statusWord_q(status),
    .reconfigReady_q(rdy), .inputEnable_q(inEn), .unityEnable_q(unityEn),
    .feedbackUsed_q(fbUsed), .synthRestartBlock_q(block), .configError_q(cfgErr));
  // ====
  // Tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checkCount++;
    if (seen !== exp) begin
      errCount++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic closeOut();
    $display("checks=%0d errors=%0d", checkCount, errCount);
    if (errCount == 0 && checkCount > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [15:0] v);
    readData = v;
    expQ.push_back(v);
    go = 1'h1;
    tick(1);
    go = 1'h0;
    tick(4);
  endtask
  // Answers are judged where they settle, away from the launching edge
  always @(negedge clk) begin
    if (rdy === 1'h1) check(status, expQ.size() ? expQ.pop_front() : 16'hXXXX);
  end
  // Effective input edges, counted away from the launching edge
  always @(negedge clk) begin
    if (inEn === 1'h1) inEnCount++;
  end
  // ====
  // Main sequence
  initial begin
    void'($urandom(32'h8D60F1D0));
    tick(2);
    reset = 1'h0;
    tick(4);
    check(status, 16'h0000);
    check({13'h0000, cfgErr, block, fbUsed}, 16'h0001);
    managerLocked = 1'h1;
    tick(60);
    check(status, 16'h0000);
    // one effective edge per input toggle without halving
    inEnCount = 16'h0000;
    tick(64);
    check(inEnCount, 16'h0008);
    for (int i = 0; i < 4; i++) rd(16'($urandom()));
    check(status, 16'h0000);
    for (int i = 0; i < 2; i++) begin
      {delayRangeHit, phaseLimitHit} = i ? 2'h2 : 2'h1;
      tick(10);
      check(status, 16'h0001);
      {delayRangeHit, phaseLimitHit} = 2'h0;
      managerLocked = 1'h0;
      tick(10);
      check(status, 16'h0000);
      managerLocked = 1'h1;
      tick(10);
    end
    fbRun = 1'h0;
    tick(20);
    fbRun = 1'h1;
    tick(40);
    check(status, 16'h0000);
    fbRun = 1'h0;
    tick(104);
    check(status, 16'h0008);
    fbRun = 1'h1;
    tick(100);
    check(status, 16'h0000);
    inRun = 1'h0;
    tick(144);
    check(status, 16'h0002);
    check({15'h0000, unityEn}, 16'h0000);
    inRun = 1'h1;
    tick(144);
    check(status, 16'h0000);
    check({15'h0000, unityEn}, 16'h0001);
    synRun = 1'h0;
    tick(16 * 255);
    check(status, 16'h0000);
    tick(16 * 6);
    check(status, 16'h0004);
    synRun = 1'h1;
    tick(200);
    check(status, 16'h0004);
    check({15'h0000, block}, 16'h0001);
    reset = 1'h1;
    tick(2);
    reset = 1'h0;
    tick(20);
    check(status, 16'h0000);
    check({15'h0000, block}, 16'h0000);
    check(16'(expQ.size()), 16'h0000);
    closeOut();
  end
endmodule
`default_nettype wire
